// [jtc_pkg.sv]
// Purpose: Shared constants and types for the tile test-port chain.
// Assumes: One TCK/TMS pair drives both TAPs in the chain.
// Notes:   Identity words are parameters of the top module.
// Overview of operation
// RULE_01: Two TAPs per tile after reset.
// RULE_02: Boundary TAP scans the I/O pins.
// RULE_03: Chip TAP reaches tile, switch, OTP.
// RULE_04: Supports loading, scan, debug, OTP programming.
// RULE_05: Five TMS-high clocks reset the port.
// RULE_06: DEVICE_IDENTIFICATION_WORD shifts version, part, maker, one.
// RULE_07: USERCODE shifts user id, unused, revision.
// RULE_08: User id from security bits 22-31.
// RULE_09: Reset async low; boot after lock.
// RULE_10: Host holds reset 100 ns past power-up.
// RULE_11: Security bit 0 disables the port.
// RULE_12: Security bit 13 blocks OTP access.
// RULE_13: Test-logic-reset loads DEVICE_IDENTIFICATION_WORD in each TAP.
// RULE_14: Sample TMS/TDI rising, drive TDO falling.
package jtc_pkg;
	localparam int         IR_W         = 4;
	localparam logic [3:0] INS_EXTEST   = 4'h0;
	localparam logic [3:0] INS_SAMPLE   = 4'h1;
	localparam logic [3:0] INS_DEVICE_IDENTIFICATION_WORD   = 4'h2;
	localparam logic [3:0] INS_USERCODE = 4'h3;
	localparam logic [3:0] INS_ACCESS   = 4'h4;
	localparam logic [3:0] INS_BYPASS   = 4'hF;
	localparam logic [3:0] IR_CAPTURE   = 4'h1;
	localparam int         ACC_W        = 43;
	localparam int         ACC_DATA_W   = 32;
	localparam int         ACC_ADDR_W   = 8;
	localparam logic [1:0] TGT_TILE     = 2'h0;
	localparam logic [1:0] TGT_SWITCH   = 2'h1;
	localparam logic [1:0] TGT_OTP      = 2'h2;
	localparam int         SEC_DIS_BIT  = 0;
	localparam int         SEC_OTP_BIT  = 13;
	localparam int         UID_LSB      = 22;
	localparam int         UID_W        = 10;
	localparam int         UNUSED_W     = 4;
	localparam int         REV_W        = 18;
	typedef enum logic [15:0] {
		TAP_RESET   = 16'h0001, TAP_IDLE    = 16'h0002,
		TAP_SEL_DR  = 16'h0004, TAP_CAP_DR  = 16'h0008,
		TAP_SH_DR   = 16'h0010, TAP_EX1_DR  = 16'h0020,
		TAP_PAU_DR  = 16'h0040, TAP_EX2_DR  = 16'h0080,
		TAP_UPD_DR  = 16'h0100, TAP_SEL_IR  = 16'h0200,
		TAP_CAP_IR  = 16'h0400, TAP_SH_IR   = 16'h0800,
		TAP_EX1_IR  = 16'h1000, TAP_PAU_IR  = 16'h2000,
		TAP_EX2_IR  = 16'h4000, TAP_UPD_IR  = 16'h8000
	} jtc_tap_t;
endpackage : jtc_pkg

// [jtc_chain.sv]
// Purpose: Boundary TAP and chip TAP in series, plus debug access bridge.
// Assumes: sec_word_i is tile 0 security register, stable after boot.
// Notes:   TDI feeds the boundary TAP; chip TAP output drives TDO.
`timescale 1ns/1ps
module jtc_chain #(
	parameter int          N_PINS   = 8,
	parameter logic [31:0] ID_WORD  = 32'h1234_5679, // Arbitrary value
	parameter logic [17:0] REV_CODE = 18'h00001      // Arbitrary value
) (
	input  wire logic                       clk_i,
	input  wire logic                       resetn_i,
	input  wire logic                       tck_i,
	input  wire logic                       tms_i,
	input  wire logic                       tdi_i,
	output logic                            tdo_o,
	output logic                            tdo_oe_n_o,
	input  wire logic [31:0]                sec_word_i,
	input  wire logic                       pll_lock_i,
	input  wire logic [1:0]                 boot_mode_i,
	output logic                            boot_go_o,
	output logic [1:0]                      boot_mode_o,
	input  wire logic [N_PINS-1:0]          pin_i,
	output logic [N_PINS-1:0]               pin_val_o,
	output logic                            pin_test_o,
	output logic                            dbg_req_o,
	output logic [1:0]                      dbg_target_o,
	output logic                            dbg_wr_o,
	output logic [jtc_pkg::ACC_ADDR_W-1:0]  dbg_addr_o,
	output logic [jtc_pkg::ACC_DATA_W-1:0]  dbg_wdata_o,
	input  wire logic                       dbg_ack_i,
	input  wire logic [jtc_pkg::ACC_DATA_W-1:0] dbg_rdata_i
);
	import jtc_pkg::*;

	jtc_tap_t                tap;
	logic [IR_W-1:0]         b_irs, c_irs, b_ins, c_ins;
	logic [31:0]             b_id;
	logic [N_PINS-1:0]       b_bs, pin_s1, pin_s2;
	logic                    b_byp, c_byp, b_out, c_out;
	logic [ACC_W-1:0]        c_sh, acc_word;
	logic [UID_W-1:0]        uid_s1, uid_s2;
	logic                    dis_s1, dis_s2;
	logic                    req_tgl, ack_s1, ack_s2, pend;
	logic                    req_s1, req_s2, req_s3, ack_tgl, busy;
	logic [ACC_DATA_W-1:0]   rd_hold;
	logic                    pll_s1, pll_s2, mode_cap;
	logic                    acc_fire, acc_block;
	logic [31:0]             user_word;

	// TAP state walk shared by both TAPs, they see the same TMS
	function automatic jtc_tap_t tap_next(input jtc_tap_t s, input logic m);
		case (s)
			TAP_RESET:  tap_next = m ? TAP_RESET  : TAP_IDLE;
			TAP_IDLE:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_SH_DR:  tap_next = m ? TAP_EX1_DR : TAP_SH_DR;
			TAP_EX1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAU_DR;
			TAP_PAU_DR: tap_next = m ? TAP_EX2_DR : TAP_PAU_DR;
			TAP_EX2_DR: tap_next = m ? TAP_UPD_DR : TAP_SH_DR;
			TAP_UPD_DR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tap_next = m ? TAP_RESET  : TAP_CAP_IR;
			TAP_CAP_IR: tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_SH_IR:  tap_next = m ? TAP_EX1_IR : TAP_SH_IR;
			TAP_EX1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAU_IR;
			TAP_PAU_IR: tap_next = m ? TAP_EX2_IR : TAP_PAU_IR;
			TAP_EX2_IR: tap_next = m ? TAP_UPD_IR : TAP_SH_IR;
			TAP_UPD_IR: tap_next = m ? TAP_SEL_DR : TAP_IDLE;
			default:    tap_next = TAP_RESET;
		endcase
	endfunction : tap_next

	// Controller; five TMS highs reach reset from any state
	always_ff @(posedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tap <= TAP_RESET;
		end else begin
			tap <= tap_next(tap, tms_i); // see RULE_05, see RULE_14
		end
	end

	// Quasi-static security bits and pins into the TCK domain
	always_ff @(posedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dis_s1 <= 1'b0;
			dis_s2 <= 1'b0;
			uid_s1 <= '0;
			uid_s2 <= '0;
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			dis_s1 <= sec_word_i[SEC_DIS_BIT];
			dis_s2 <= dis_s1;
			uid_s1 <= sec_word_i[UID_LSB +: UID_W];
			uid_s2 <= uid_s1;
			pin_s1 <= pin_i;
			pin_s2 <= pin_s1;
		end
	end

	// User id, spare, revision; zero id on a blank part
	assign user_word = {uid_s2, {UNUSED_W{1'b0}}, REV_CODE}; // see RULE_07, see RULE_08

	// Instruction registers; secured port takes bypass on IR update
	always_ff @(posedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			b_irs <= IR_CAPTURE;
			c_irs <= IR_CAPTURE;
			b_ins <= INS_DEVICE_IDENTIFICATION_WORD;
			c_ins <= INS_DEVICE_IDENTIFICATION_WORD;
		end else begin
			case (tap)
				TAP_RESET: begin
					b_ins <= INS_DEVICE_IDENTIFICATION_WORD; // see RULE_13
					c_ins <= INS_DEVICE_IDENTIFICATION_WORD; // see RULE_13
				end
				TAP_CAP_IR: begin
					b_irs <= IR_CAPTURE;
					c_irs <= IR_CAPTURE;
				end
				TAP_SH_IR: begin
					b_irs <= {tdi_i, b_irs[IR_W-1:1]};
					c_irs <= {b_irs[0], c_irs[IR_W-1:1]}; // see RULE_01
				end
				TAP_UPD_IR: begin
					b_ins <= dis_s2 ? INS_BYPASS : b_irs; // see RULE_11
					c_ins <= dis_s2 ? INS_BYPASS : c_irs; // see RULE_11
				end
				default: b_ins <= b_ins;
			endcase
		end
	end

	// Boundary TAP data registers: id word, pin cells, bypass
	always_ff @(posedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			b_id  <= '0;
			b_bs  <= '0;
			b_byp <= 1'b0;
		end else if (tap == TAP_CAP_DR) begin
			b_id  <= (b_ins == INS_USERCODE) ? user_word : ID_WORD; // see RULE_06
			b_bs  <= pin_s2; // see RULE_02
			b_byp <= 1'b0;
		end else if (tap == TAP_SH_DR) begin
			b_id  <= {tdi_i, b_id[31:1]};
			b_bs  <= {tdi_i, b_bs[N_PINS-1:1]};
			b_byp <= tdi_i;
		end
	end

	// Serial out of the boundary TAP's selected register
	always_comb begin
		case (b_ins)
			INS_EXTEST, INS_SAMPLE:   b_out = b_bs[0];
			INS_DEVICE_IDENTIFICATION_WORD, INS_USERCODE: b_out = b_id[0];
			default:                  b_out = b_byp;
		endcase
	end

	// Pin drive from the update stage; EXTEST owns the pins
	always_ff @(posedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_val_o  <= '0;
			pin_test_o <= 1'b0;
		end else begin
			if (tap == TAP_UPD_DR && b_ins == INS_EXTEST) begin
				pin_val_o <= b_bs; // see RULE_02
			end
			pin_test_o <= (b_ins == INS_EXTEST) && !dis_s2;
		end
	end

	// Chip TAP: one shift register serves id, usercode and access
	always_ff @(posedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			c_sh  <= '0;
			c_byp <= 1'b0;
		end else if (tap == TAP_CAP_DR) begin
			c_byp <= 1'b0;
			case (c_ins)
				INS_DEVICE_IDENTIFICATION_WORD:   c_sh <= {11'h000, ID_WORD}; // see RULE_06
				INS_USERCODE: c_sh <= {11'h000, user_word}; // see RULE_07
				INS_ACCESS:   c_sh <= {10'h000, pend, pend ? 32'h0000_0000 : rd_hold};
				default:      c_sh <= c_sh;
			endcase
		end else if (tap == TAP_SH_DR) begin
			// Id and usercode paths are 32 long, so the chain matches a plain TAP
			c_sh  <= (c_ins == INS_ACCESS) ? {b_out, c_sh[ACC_W-1:1]}
				: {11'h000, b_out, c_sh[ACC_DATA_W-1:1]}; // see RULE_01, see RULE_06
			c_byp <= b_out;
		end
	end

	assign c_out = (c_ins == INS_DEVICE_IDENTIFICATION_WORD || c_ins == INS_USERCODE
		|| c_ins == INS_ACCESS) ? c_sh[0] : c_byp;

	// Access launch; a word arriving while one is pending is dropped
	always_ff @(posedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			acc_word <= '0;
			req_tgl  <= 1'b0;
		end else if (tap == TAP_UPD_DR && c_ins == INS_ACCESS && !pend && !dis_s2) begin
			acc_word <= c_sh; // see RULE_03, see RULE_04
			req_tgl  <= ~req_tgl;
		end
	end

	// Completion toggle back from the core clock
	always_ff @(posedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			ack_s1 <= ack_tgl;
			ack_s2 <= ack_s1;
		end
	end

	assign pend = req_tgl ^ ack_s2;

	// TDO moves on the falling edge so the host samples mid-bit
	always_ff @(negedge tck_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tdo_o      <= 1'b0;
			tdo_oe_n_o <= 1'b1;
		end else begin
			tdo_o      <= (tap == TAP_SH_IR) ? c_irs[0] : c_out; // see RULE_14
			tdo_oe_n_o <= dis_s2 || !(tap == TAP_SH_IR || tap == TAP_SH_DR); // see RULE_11
		end
	end

	// Core side: request toggle synchroniser plus edge stage
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			req_s3 <= 1'b0;
		end else begin
			req_s1 <= req_tgl;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end

	assign acc_fire  = req_s2 ^ req_s3;
	assign acc_block = acc_word[ACC_W-1 -: 2] == TGT_OTP && sec_word_i[SEC_OTP_BIT];

	// acc_word is stable while the toggle is in flight, safe to read here
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			dbg_req_o    <= 1'b0;
			dbg_target_o <= TGT_TILE;
			dbg_wr_o     <= 1'b0;
			dbg_addr_o   <= '0;
			dbg_wdata_o  <= '0;
			busy         <= 1'b0;
			ack_tgl      <= 1'b0;
			rd_hold      <= '0;
		end else begin
			dbg_req_o <= acc_fire && !acc_block; // see RULE_12, see RULE_03
			if (acc_fire && acc_block) begin
				rd_hold <= '0; // see RULE_12
				ack_tgl <= ~ack_tgl;
			end else if (acc_fire) begin
				dbg_target_o <= acc_word[ACC_W-1 -: 2];
				dbg_wr_o     <= acc_word[ACC_W-3];
				dbg_addr_o   <= acc_word[ACC_DATA_W +: ACC_ADDR_W];
				dbg_wdata_o  <= acc_word[ACC_DATA_W-1:0];
				busy         <= 1'b1;
			end else if (busy && dbg_ack_i) begin
				rd_hold <= dbg_rdata_i;
				busy    <= 1'b0;
				ack_tgl <= ~ack_tgl;
			end
		end
	end

	// Boot waits for PLL lock; mode strap caught after release
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pll_s1      <= 1'b0;
			pll_s2      <= 1'b0;
			boot_go_o   <= 1'b0;
			boot_mode_o <= 2'h0;
			mode_cap    <= 1'b0;
		end else begin
			pll_s1   <= pll_lock_i;
			pll_s2   <= pll_s1;
			mode_cap <= 1'b1;
			if (!mode_cap) begin
				boot_mode_o <= boot_mode_i;
			end
			if (pll_s2 && mode_cap) begin
				boot_go_o <= 1'b1; // see RULE_09
			end
		end
	end

	AST_FIVE_TMS_RESET: assert property ( // see RULE_05
		@(posedge tck_i) disable iff (!resetn_i)
		tms_i [*5] |=> (tap == TAP_RESET))
		else $error("five TMS highs did not reach reset");
	AST_RESET_LOADS_ID: assert property ( // see RULE_13
		@(posedge tck_i) disable iff (!resetn_i)
		(tap == TAP_RESET) |=> (b_ins == INS_DEVICE_IDENTIFICATION_WORD && c_ins == INS_DEVICE_IDENTIFICATION_WORD))
		else $error("reset state did not load DEVICE_IDENTIFICATION_WORD");
	AST_DEVICE_IDENTIFICATION_WORD_WORD: assert property ( // see RULE_06
		@(posedge tck_i) disable iff (!resetn_i)
		(tap == TAP_CAP_DR && c_ins == INS_DEVICE_IDENTIFICATION_WORD)
		|=> (c_sh[31:0] == ID_WORD && c_sh[0]))
		else $error("chip TAP captured wrong id word");
	AST_USER_ID_FIELD: assert property ( // see RULE_08
		@(posedge tck_i) disable iff (!resetn_i)
		(tap == TAP_CAP_DR && c_ins == INS_USERCODE)
		|=> (c_sh[31:22] == $past(uid_s2) && c_sh[REV_W-1:0] == REV_CODE))
		else $error("usercode fields wrong");
	AST_TDO_DRIVEN_IN_SHIFT: assert property ( // see RULE_14
		@(negedge tck_i) disable iff (!resetn_i)
		(tap == TAP_SH_DR && !dis_s2) |=> !tdo_oe_n_o)
		else $error("TDO not driven during shift");
	AST_DISABLED_QUIET: assert property ( // see RULE_11
		@(posedge tck_i) disable iff (!resetn_i)
		dis_s2 [*2] |-> (tdo_oe_n_o && !pin_test_o && $stable(req_tgl)))
		else $error("secured port drove TDO");
	AST_OTP_BLOCKED: assert property ( // see RULE_12
		@(posedge clk_i) disable iff (!resetn_i)
		(acc_fire && acc_block) |=> (!dbg_req_o && !busy && rd_hold == '0))
		else $error("OTP access passed while blocked");
	AST_ACCESS_ISSUED: assert property ( // see RULE_03
		@(posedge clk_i) disable iff (!resetn_i)
		(acc_fire && !acc_block) |=> (dbg_req_o && busy
		&& dbg_target_o == $past(acc_word[ACC_W-1 -: 2])) ##1 !dbg_req_o)
		else $error("access request not issued once");
	AST_BOOT_AFTER_LOCK: assert property ( // see RULE_09
		@(posedge clk_i) disable iff (!resetn_i)
		$rose(boot_go_o) |-> ($past(pll_s2) && $past(mode_cap)))
		else $error("boot started before PLL lock");
endmodule : jtc_chain

// [jtc_host.sv]
// Purpose: Behavioural JTAG host that clocks the test-port chain.
// Assumes: 160 ns test clock, parked low between frames.
// Notes:   The bench calls these tasks through the instance.
`timescale 1ns/1ps
module jtc_host (
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	input  wire logic tdo_i,
	input  wire logic tdo_oe_n_i
);
	// Idle levels; TCK stands still outside frames
	initial begin
		tck_o = 1'b0;
		tms_o = 1'b1;
		tdi_o = 1'b0;
	end

	// One clock: inputs move while low, TDO read just before the rise
	task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
		tms_o = tms;
		tdi_o = tdi;
		#80;
		tdo   = tdo_i;
		oe_n  = tdo_oe_n_i;
		tck_o = 1'b1;
		#80;
		tck_o = 1'b0;
	endtask : step

	// Five TMS highs force the port reset, then park in idle
	task automatic reset5();
		logic b;
		logic o;
		repeat (5) step(1'b1, 1'b0, b, o);
		step(1'b0, 1'b0, b, o);
	endtask : reset5

	// Idle to shift, n bits LSB first, update, back to idle
	task automatic scan(input logic ir, input int n, input logic [63:0] din,
			output logic [63:0] dout, output int nlow);
		logic b;
		logic o;
		dout = 64'h0;
		nlow = 0;
		step(1'b1, 1'b0, b, o);
		if (ir)
			step(1'b1, 1'b0, b, o);
		repeat (2) step(1'b0, 1'b0, b, o);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], b, o);
			dout[i] = b;
			nlow += (o === 1'b0);
		end
		step(1'b1, 1'b0, b, o);
		step(1'b0, 1'b0, b, o);
	endtask : scan
endmodule : jtc_host

// [jtc_chain_test.sv]
// Purpose: Self-checking bench for the two-TAP test-port chain.
// Assumes: Host model makes TCK; the bench plays the access target.
// Notes:   Boundary bit 0 is taken to be pin 0.
`timescale 1ns/1ps
module jtc_chain_test;
	import jtc_pkg::*;
	localparam logic [31:0] TB_ID  = 32'h1A2B3C4D; // Arbitrary value, bit 0 set
	localparam logic [17:0] TB_REV = 18'h15A5A;    // Arbitrary value
	logic        clk       = 1'b0;
	logic        resetn    = 1'b0;
	logic        tck, tms, tdi, tdo, tdo_oe_n, b, o;
	logic [31:0] sec       = 32'h0;
	logic        pll_lock  = 1'b0;
	logic [1:0]  boot_mode = 2'h2;
	logic        boot_go, pin_test, dbg_req, dbg_wr;
	logic [1:0]  boot_mode_q, dbg_target;
	logic [7:0]  pins      = 8'h3C;
	logic [7:0]  pin_val, dbg_addr;
	logic [31:0] dbg_wdata;
	logic        dbg_ack   = 1'b0;
	logic [31:0] dbg_rdata = 32'h0;
	logic [63:0] d;
	int          n;
	int          reqs        = 0;
	int          failures    = 0;
	int          check_count = 0;

	jtc_chain #(.N_PINS(8), .ID_WORD(TB_ID), .REV_CODE(TB_REV)) i_dut (
		.clk_i(clk), .resetn_i(resetn), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.tdo_o(tdo), .tdo_oe_n_o(tdo_oe_n), .sec_word_i(sec), .pll_lock_i(pll_lock),
		.boot_mode_i(boot_mode), .boot_go_o(boot_go), .boot_mode_o(boot_mode_q),
		.pin_i(pins), .pin_val_o(pin_val), .pin_test_o(pin_test), .dbg_req_o(dbg_req),
		.dbg_target_o(dbg_target), .dbg_wr_o(dbg_wr), .dbg_addr_o(dbg_addr),
		.dbg_wdata_o(dbg_wdata), .dbg_ack_i(dbg_ack), .dbg_rdata_i(dbg_rdata));
	jtc_host i_host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
		.tdo_oe_n_i(tdo_oe_n));

	// Core clock; requests counted on the falling edge where they are settled
	always #10 clk = ~clk;
	always @(negedge clk) if (dbg_req === 1'b1) reqs <= reqs + 1;

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : check

	task automatic wait_clk(input int k);
		repeat (k) @(posedge clk);
	endtask : wait_clk

	task automatic set_sec(input logic [31:0] v);
		@(posedge clk);
		sec <= v;
		wait_clk(4);
	endtask : set_sec

	task automatic end_sim();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_sim

	task automatic t_boot();
		check(boot_go, 1'b0);
		@(posedge clk);
		pll_lock <= 1'b1;
		wait_clk(8);
		check({boot_go, boot_mode_q}, 3'h6);
		resetn <= 1'b0;
		#1;
		check({boot_go, tdo_oe_n}, 2'h1);
		i_host.step(1'b1, 1'b0, b, o);
		wait_clk(8);
		resetn <= 1'b1;
		wait_clk(8);
		check(boot_go, 1'b1);
	endtask : t_boot

	task automatic t_device_identification_word();
		i_host.reset5();
		i_host.scan(1'b0, 64, 64'h0, d, n);
		check(d, {TB_ID, TB_ID});
		check(d[0], 1'b1);
		check(n, 64);
		i_host.step(1'b0, 1'b0, b, o);
		check(o, 1'b1);
	endtask : t_device_identification_word

	task automatic t_user();
		set_sec({10'h2A5, 22'h0});
		i_host.scan(1'b1, 8, {56'h0, INS_USERCODE, INS_USERCODE}, d, n);
		check(d[7:0], {IR_CAPTURE, IR_CAPTURE});
		i_host.scan(1'b0, 64, 64'h0, d, n);
		check(d, {2{10'h2A5, 4'h0, TB_REV}});
		set_sec(32'h0);
		i_host.scan(1'b0, 64, 64'h0, d, n);
		check(d, {2{14'h0, TB_REV}});
	endtask : t_user

	task automatic t_reset5();
		i_host.scan(1'b1, 8, 64'hFF, d, n);
		i_host.scan(1'b0, 2, 64'h3, d, n);
		check(d[1:0], 2'h0);
		i_host.reset5();
		i_host.scan(1'b0, 32, 64'h0, d, n);
		check(d[31:0], TB_ID);
	endtask : t_reset5

	task automatic t_extest();
		i_host.scan(1'b1, 8, {56'h0, INS_SAMPLE, INS_BYPASS}, d, n);
		i_host.scan(1'b0, 9, 64'h0, d, n);
		check(d[8:1], pins);
		check({pin_test, pin_val}, 9'h000);
		i_host.scan(1'b1, 8, {56'h0, INS_EXTEST, INS_BYPASS}, d, n);
		i_host.step(1'b0, 1'b0, b, o);
		check(pin_test, 1'b1);
		i_host.scan(1'b0, 9, {55'h0, 8'hA6, 1'b0}, d, n);
		check({pin_val, d[8:1]}, 16'hA63C);
	endtask : t_extest

	// One access frame; go says whether a request must reach the target
	task automatic acc(input logic [42:0] f, input logic go, input logic [31:0] rd,
			input logic [32:0] cap);
		int r0;
		r0 = reqs;
		i_host.scan(1'b0, 44, {21'h0, f}, d, n);
		check(d[32:0], cap);
		for (int k = 0; k < 40 && reqs == r0; k++)
			@(posedge clk);
		wait_clk(40 * !go);
		check({reqs != r0, go ? {dbg_target, dbg_wr, dbg_addr, dbg_wdata} : f},
			{go, f});
		if (go) begin
			@(posedge clk);
			dbg_ack   <= 1'b1;
			dbg_rdata <= rd;
			@(posedge clk);
			dbg_ack   <= 1'b0;
		end
		repeat (6) i_host.step(1'b0, 1'b0, b, o);
	endtask : acc

	task automatic t_access();
		i_host.scan(1'b1, 8, {56'h0, INS_BYPASS, INS_ACCESS}, d, n);
		acc({TGT_TILE, 1'b0, 8'h5A, 32'h0}, 1'b1, 32'hC0DE1234, 33'h0);
		acc({TGT_SWITCH, 1'b1, 8'h11, 32'hBEEF0055}, 1'b1, 32'h5555AAAA,
			{1'b0, 32'hC0DE1234});
		set_sec(32'h2000);
		acc({TGT_OTP, 1'b0, 8'h22, 32'h0}, 1'b0, 32'h0, {1'b0, 32'h5555AAAA});
		acc({TGT_OTP, 1'b1, 8'h33, 32'h12345678}, 1'b0, 32'h0, 33'h0);
	endtask : t_access

	task automatic t_secure();
		set_sec(32'h1);
		i_host.reset5();
		i_host.scan(1'b0, 64, 64'h0, d, n);
		check(n, 0);
		i_host.scan(1'b1, 8, {56'h0, INS_EXTEST, INS_BYPASS}, d, n);
		i_host.step(1'b0, 1'b0, b, o);
		check(pin_test, 1'b0);
	endtask : t_secure

	// Reset spans one full test clock cycle, rise and fall, and then eight core clocks; then the scenarios in turn
	initial begin
		i_host.step(1'b1, 1'b0, b, o);
		wait_clk(8);
		resetn <= 1'b1;
		wait_clk(2);
		t_boot();
		t_device_identification_word();
		t_user();
		t_reset5();
		t_extest();
		t_access();
		t_secure();
		end_sim();
	end

	// Watchdog well beyond the expected run of about 110 microseconds
	initial begin
		#1000000;
		failures++;
		end_sim();
	end
endmodule : jtc_chain_test
